// *** rtl/llc_pkg.sv ***
`default_nettype none
// ==================================================
// shared constants for the logic table / options bank
package llc_pkg;
  // ==================================================
  // register offsets
  localparam logic [7:0] LUT3_BANK_B_OFS  = 8'h28;
  localparam logic [7:0] LUT3_BANK_A_OFS  = 8'h29;
  localparam logic [7:0] LUT4_BANK_B_OFS  = 8'h2a;
  localparam logic [7:0] LUT4_BANK_A_OFS  = 8'h2b;
  localparam logic [7:0] EXTRA_OPTS_OFS   = 8'had;
  // port value registers live outside this block; only their reads are watched
  localparam logic [7:0] PORT_VAL_B_OFS   = 8'h10;
  localparam logic [7:0] PORT_VAL_A_OFS   = 8'h11;

  // ==================================================
  // reset values and the unmapped read value
  localparam logic [7:0] LUT_RESET        = 8'h00;
  localparam logic [7:0] EXTRA_OPTS_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED    = 8'h00;

  // ==================================================
  // field positions in extra_options
  localparam int unsigned AUTOCLR_BIT     = 2;
  localparam int unsigned BOOST_BIT       = 1;

  // ==================================================
  // low logic-mode field value that selects the 3-to-2 function
  localparam logic [1:0] LOGIC_MODE_3TO2  = 2'h3;

  // ==================================================
  // bus framing count and default device address
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h20;  // arbitrary default address

  // serial engine states
  typedef enum logic [3:0] {
    LLC_IDLE,
    LLC_ADDR,
    LLC_ACK_ADDR,
    LLC_PTR,
    LLC_ACK_PTR,
    LLC_WR,
    LLC_ACK_WR,
    LLC_RD,
    LLC_RD_ACK
  } llc_state_t;
endpackage
`default_nettype wire

// *** rtl/llc_lut_sel.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// one bank: two table lookups on a 3-bit pin code
module llc_lut_sel (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  // selection
  input  wire logic [1:0] mode_low_i,    // bank low logic-mode field
  input  wire logic [2:0] code_i,        // three neighbouring pins
  // tables
  input  wire logic [7:0] lut3_i,        // third table of the bank
  input  wire logic [7:0] lut4_i,        // fourth table of the bank
  // results
  output logic      [1:0] out_o,         // {fourth, third} table bit
  output logic            drive_o        // high while tables own the pins
);
  logic sel_3to2;  // this bank is in 3-to-2 mode

  assign sel_3to2 = (mode_low_i == llc_pkg::LOGIC_MODE_3TO2);

  // ==================================================
  // registered lookup; zero outside 3-to-2 so a stale table cannot leak
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      out_o   <= 2'h0;
      drive_o <= 1'b0;
    end else if (sel_3to2) begin
      out_o   <= {lut4_i[code_i], lut3_i[code_i]};  // [R1] [R2] [R3] [R4]
      drive_o <= 1'b1;                              // [R5]
    end else begin
      out_o   <= 2'h0;                              // [R5]
      drive_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** rtl/llc_top.sv ***
// Contract
// R1: bank B pin 11 from table three
// R2: bank A pin 3 from table three
// R3: bank B pin 12 from table four
// R4: bank A pin 4 from table four
// R5: tables act only in 3-to-2 mode
// R6: four tables, 8 bits, reset zero
// R7: autoclear set: port reads clear interrupt flags
// R8: autoclear off: host clears flags itself
// R9: option bit 1 enables boost, reset off
// R10: host writes reserved option bits zero
// R11: host writes ones to clear sources
// R12: tables always readable and writable
`timescale 1ns/1ps
`default_nettype none
module llc_top #(
  parameter logic [6:0] DEV_ADDR = llc_pkg::DEV_ADDR_DEFAULT  // arbitrary value
) (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  // serial bus pins, sampled on ref_clk_i
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // pins and mode fields from the expander core
  input  wire logic [15:0] io_i,
  input  wire logic [1:0] logic_mode_low_bank_a_i,
  input  wire logic [1:0] logic_mode_low_bank_b_i,
  input  wire logic [7:0] port_value_bank_a_i,
  input  wire logic [7:0] port_value_bank_b_i,
  // table outputs
  output logic            io3_o,
  output logic            io4_o,
  output logic            io11_o,
  output logic            io12_o,
  output logic            lut_drive_bank_a_o,
  output logic            lut_drive_bank_b_o,
  // option outputs
  output logic            boost_en_o,
  output logic            irq_autoclear_o
);
  // ==================================================
  // declarations
  llc_pkg::llc_state_t state_reg;        // serial engine state
  logic [3:0]  bit_cnt_reg;              // bits of current byte
  logic [7:0]  shift_reg;                // receive shifter
  logic [7:0]  tx_reg;                   // transmit shifter
  logic [7:0]  ptr_reg;                  // register pointer
  logic        rw_reg;                   // 1 for a read transfer
  logic        sda_oe_reg;               // pull sda low
  logic        scl_prev_reg;             // last scl sample
  logic        sda_prev_reg;             // last sda sample
  logic [7:0]  lut3_b_reg;               // lut3_bank_b
  logic [7:0]  lut3_a_reg;               // lut3_bank_a
  logic [7:0]  lut4_b_reg;               // lut4_bank_b
  logic [7:0]  lut4_a_reg;               // lut4_bank_a
  logic [7:0]  extra_opts_reg;           // extra_options
  logic        scl_rise;                 // scl low to high
  logic        scl_fall;                 // scl high to low
  logic        bus_start;                // start or repeated start
  logic        bus_stop;                 // stop condition
  logic        byte_done;                // eighth bit clocked in
  logic        wr_stb;                   // one-cycle register write
  logic        rd_load;                  // one-cycle load of a read byte
  logic [7:0]  rd_addr;                  // address being loaded
  logic [7:0]  rd_data;                  // read mux result
  logic [1:0]  bank_out [2];             // per-bank table bits
  logic        bank_drv [2];             // per-bank drive flag
  logic [1:0]  bank_mode [2];            // per-bank mode field
  logic [7:0]  bank_lut3 [2];            // per-bank third table
  logic [7:0]  bank_lut4 [2];            // per-bank fourth table

  // ==================================================
  // bus event decode; pins are already synchronous
  assign scl_rise  = scl_i & ~scl_prev_reg;
  assign scl_fall  = ~scl_i & scl_prev_reg;
  assign bus_start = scl_i & scl_prev_reg & sda_prev_reg & ~sda_i;
  assign bus_stop  = scl_i & scl_prev_reg & ~sda_prev_reg & sda_i;
  assign byte_done = (bit_cnt_reg == llc_pkg::BITS_PER_BYTE);

  // write lands when a data byte completes, in the same cycle its acknowledge is driven
  assign wr_stb  = (state_reg == llc_pkg::LLC_WR) & scl_fall & byte_done & ~bus_start;
  // a read byte is fetched after address ack or after master ack
  assign rd_load = scl_fall & ~bus_start & ~bus_stop & rw_reg &
                   ((state_reg == llc_pkg::LLC_ACK_ADDR) |
                    (state_reg == llc_pkg::LLC_RD_ACK));
  assign rd_addr = ptr_reg;

  // open drain: the pad only ever pulls low
  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_oe_reg;

  // ==================================================
  // read mux
  always_comb begin
    case (rd_addr)
      llc_pkg::LUT3_BANK_B_OFS: rd_data = lut3_b_reg;      // [R12]
      llc_pkg::LUT3_BANK_A_OFS: rd_data = lut3_a_reg;      // [R12]
      llc_pkg::LUT4_BANK_B_OFS: rd_data = lut4_b_reg;      // [R12]
      llc_pkg::LUT4_BANK_A_OFS: rd_data = lut4_a_reg;      // [R12]
      llc_pkg::EXTRA_OPTS_OFS:  rd_data = extra_opts_reg;
      llc_pkg::PORT_VAL_B_OFS:  rd_data = port_value_bank_b_i;
      llc_pkg::PORT_VAL_A_OFS:  rd_data = port_value_bank_a_i;
      default:                  rd_data = llc_pkg::READ_UNMAPPED;
    endcase
  end

  // ==================================================
  // pin history for edge detection
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_i;
      sda_prev_reg <= sda_i;
    end
  end

  // ==================================================
  // serial engine: address, pointer, write and read bytes
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      state_reg   <= llc_pkg::LLC_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      tx_reg      <= 8'h00;
      ptr_reg     <= 8'h00;
      rw_reg      <= 1'b0;
      sda_oe_reg  <= 1'b0;
    end else if (bus_start) begin
      // repeated start keeps the pointer so a read can follow a pointer write
      state_reg   <= llc_pkg::LLC_ADDR;
      bit_cnt_reg <= 4'h0;
      rw_reg      <= 1'b0;
      sda_oe_reg  <= 1'b0;
    end else if (bus_stop) begin
      state_reg   <= llc_pkg::LLC_IDLE;
      sda_oe_reg  <= 1'b0;
    end else begin
      case (state_reg)
        llc_pkg::LLC_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        llc_pkg::LLC_ADDR, llc_pkg::LLC_PTR, llc_pkg::LLC_WR: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_i};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && byte_done) begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == llc_pkg::LLC_ADDR) begin
              // foreign address: stay silent until the next start
              if (shift_reg[7:1] == DEV_ADDR) begin
                rw_reg     <= shift_reg[0];
                sda_oe_reg <= 1'b1;
                state_reg  <= llc_pkg::LLC_ACK_ADDR;
              end else begin
                state_reg  <= llc_pkg::LLC_IDLE;
              end
            end else if (state_reg == llc_pkg::LLC_PTR) begin
              ptr_reg    <= shift_reg;
              sda_oe_reg <= 1'b1;
              state_reg  <= llc_pkg::LLC_ACK_PTR;
            end else begin
              sda_oe_reg <= 1'b1;
              state_reg  <= llc_pkg::LLC_ACK_WR;
            end
          end
        end
        llc_pkg::LLC_ACK_ADDR: begin
          if (scl_fall) begin
            if (rw_reg) begin
              tx_reg     <= rd_data;
              sda_oe_reg <= ~rd_data[7];
              state_reg  <= llc_pkg::LLC_RD;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg  <= llc_pkg::LLC_PTR;
            end
          end
        end
        llc_pkg::LLC_ACK_PTR: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            state_reg  <= llc_pkg::LLC_WR;
          end
        end
        llc_pkg::LLC_ACK_WR: begin
          if (scl_fall) begin
            // pointer advances so bursts walk through the map
            sda_oe_reg <= 1'b0;
            ptr_reg    <= ptr_reg + 8'h01;
            state_reg  <= llc_pkg::LLC_WR;
          end
        end
        llc_pkg::LLC_RD: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (byte_done) begin
              bit_cnt_reg <= 4'h0;
              sda_oe_reg  <= 1'b0;
              ptr_reg     <= ptr_reg + 8'h01;
              state_reg   <= llc_pkg::LLC_RD_ACK;
            end else begin
              tx_reg     <= {tx_reg[6:0], 1'b0};
              sda_oe_reg <= ~tx_reg[6];
            end
          end
        end
        llc_pkg::LLC_RD_ACK: begin
          if (scl_rise && sda_i) begin
            // master nack ends the read; wait for stop or start
            state_reg <= llc_pkg::LLC_IDLE;
          end else if (scl_fall) begin
            tx_reg     <= rd_data;
            sda_oe_reg <= ~rd_data[7];
            state_reg  <= llc_pkg::LLC_RD;
          end
        end
        default: begin
          state_reg  <= llc_pkg::LLC_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // ==================================================
  // register file; tables stay writable in every mode
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      lut3_b_reg     <= llc_pkg::LUT_RESET;             // [R6]
      lut3_a_reg     <= llc_pkg::LUT_RESET;             // [R6]
      lut4_b_reg     <= llc_pkg::LUT_RESET;             // [R6]
      lut4_a_reg     <= llc_pkg::LUT_RESET;             // [R6]
      extra_opts_reg <= llc_pkg::EXTRA_OPTS_RESET;      // [R9]
    end else if (wr_stb) begin
      case (ptr_reg)
        llc_pkg::LUT3_BANK_B_OFS: lut3_b_reg <= shift_reg;  // [R12]
        llc_pkg::LUT3_BANK_A_OFS: lut3_a_reg <= shift_reg;  // [R12]
        llc_pkg::LUT4_BANK_B_OFS: lut4_b_reg <= shift_reg;  // [R12]
        llc_pkg::LUT4_BANK_A_OFS: lut4_a_reg <= shift_reg;  // [R12]
        llc_pkg::EXTRA_OPTS_OFS: begin
          // reserved bits are not stored, so they always read zero
          extra_opts_reg <= 8'h00;
          extra_opts_reg[llc_pkg::AUTOCLR_BIT] <= shift_reg[llc_pkg::AUTOCLR_BIT];
          extra_opts_reg[llc_pkg::BOOST_BIT]   <= shift_reg[llc_pkg::BOOST_BIT];  // [R9]
        end
        default: begin
          // unmapped writes are acknowledged and dropped
        end
      endcase
    end
  end

  // ==================================================
  // option outputs
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      boost_en_o      <= 1'b0;
      irq_autoclear_o <= 1'b0;
    end else begin
      boost_en_o      <= extra_opts_reg[llc_pkg::BOOST_BIT];  // [R9]
      // manual clearing stays with the host when the bit is off
      irq_autoclear_o <= rd_load & extra_opts_reg[llc_pkg::AUTOCLR_BIT] &
                         ((rd_addr == llc_pkg::PORT_VAL_A_OFS) |
                          (rd_addr == llc_pkg::PORT_VAL_B_OFS));  // [R7] [R8]
    end
  end

  // ==================================================
  // per-bank table lookups: index 0 bank A, index 1 bank B
  assign bank_mode[0] = logic_mode_low_bank_a_i;
  assign bank_mode[1] = logic_mode_low_bank_b_i;
  assign bank_lut3[0] = lut3_a_reg;
  assign bank_lut3[1] = lut3_b_reg;
  assign bank_lut4[0] = lut4_a_reg;
  assign bank_lut4[1] = lut4_b_reg;

  for (genvar g = 0; g < 2; g++) begin : g_bank
    llc_lut_sel u_sel (
      .ref_clk_i  (ref_clk_i),
      .rst_b_i    (rst_b_i),
      .mode_low_i (bank_mode[g]),
      .code_i     (io_i[g*8 +: 3]),
      .lut3_i     (bank_lut3[g]),
      .lut4_i     (bank_lut4[g]),
      .out_o      (bank_out[g]),
      .drive_o    (bank_drv[g])
    );
  end

  assign io3_o              = bank_out[0][0];  // [R2]
  assign io4_o              = bank_out[0][1];  // [R4]
  assign io11_o             = bank_out[1][0];  // [R1]
  assign io12_o             = bank_out[1][1];  // [R3]
  assign lut_drive_bank_a_o = bank_drv[0];
  assign lut_drive_bank_b_o = bank_drv[1];
endmodule
`default_nettype wire

// *** tb/llc_top_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// port-level checks for the table and options bank
module llc_top_properties (
  // clock and reset
  input wire logic       ref_clk_i,
  input wire logic       rst_b_i,
  // bus and mode inputs
  input wire logic       scl_i,
  input wire logic [1:0] logic_mode_low_bank_a_i,
  input wire logic [1:0] logic_mode_low_bank_b_i,
  // outputs watched
  input wire logic       sda_oe_o,
  input wire logic       io3_o,
  input wire logic       io4_o,
  input wire logic       io11_o,
  input wire logic       io12_o,
  input wire logic       lut_drive_bank_a_o,
  input wire logic       lut_drive_bank_b_o,
  input wire logic       boost_en_o,
  input wire logic       irq_autoclear_o
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  // ==========
  // table outputs follow the mode one cycle later
  drive_a_off_a: assert property (
    logic_mode_low_bank_a_i != llc_pkg::LOGIC_MODE_3TO2 |=>
    !lut_drive_bank_a_o && !io3_o && !io4_o) else $error("bank a drives outside 3-to-2");
  drive_b_off_a: assert property (
    logic_mode_low_bank_b_i != llc_pkg::LOGIC_MODE_3TO2 |=>
    !lut_drive_bank_b_o && !io11_o && !io12_o) else $error("bank b drives outside 3-to-2");
  drive_a_on_a: assert property (
    logic_mode_low_bank_a_i == llc_pkg::LOGIC_MODE_3TO2 |=> lut_drive_bank_a_o)
    else $error("bank a not driving in 3-to-2");
  drive_b_on_a: assert property (
    logic_mode_low_bank_b_i == llc_pkg::LOGIC_MODE_3TO2 |=> lut_drive_bank_b_o)
    else $error("bank b not driving in 3-to-2");

  // ==========
  // options and bus timing
  boost_after_ack_a: assert property (
    $changed(boost_en_o) |-> $past(sda_oe_o)) else $error("boost moved without a write");
  clear_pulse_a: assert property (
    irq_autoclear_o |=> !irq_autoclear_o) else $error("autoclear pulse too long");
  clear_in_low_a: assert property (
    irq_autoclear_o |-> !scl_i && !$past(scl_i)) else $error("autoclear outside byte fetch");
  sda_low_phase_a: assert property (
    $changed(sda_oe_o) |-> !$past(scl_i)) else $error("data moved while clock high");
endmodule

bind llc_top llc_top_properties u_props (
  .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
  .logic_mode_low_bank_a_i(logic_mode_low_bank_a_i),
  .logic_mode_low_bank_b_i(logic_mode_low_bank_b_i),
  .io3_o(io3_o), .io4_o(io4_o), .io11_o(io11_o), .io12_o(io12_o),
  .lut_drive_bank_a_o(lut_drive_bank_a_o), .lut_drive_bank_b_o(lut_drive_bank_b_o),
  .boost_en_o(boost_en_o), .irq_autoclear_o(irq_autoclear_o)
);
`default_nettype wire

// *** tb/llc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// serial bus host: makes the clock, pulls data low by its enable
module llc_host_model (
  // clock
  input  wire logic ref_clk_i,
  // bus pins
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  // bus idles released; the pull-up gives a high line
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // four-cycle phases keep the three-cycle minimum with margin
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // start or repeated start: data falls while the clock is high
  task automatic go;
    sda_oe_o <= 1'b0;
    tk(4);
    scl_o <= 1'b1;
    tk(4);
    sda_oe_o <= 1'b1;
    tk(4);
    scl_o <= 1'b0;
    tk(1);
  endtask
  // stop: data rises while the clock is high
  task automatic stp;
    sda_oe_o <= 1'b1;
    tk(4);
    scl_o <= 1'b1;
    tk(4);
    sda_oe_o <= 1'b0;
    tk(8);
  endtask
  // one bit; a one releases the line so the device may answer
  task automatic bit_io(input logic b, output logic r);
    sda_oe_o <= ~b;
    tk(4);
    scl_o <= 1'b1;
    tk(3);
    r = sda_i;
    tk(2);
    scl_o <= 1'b0;
    tk(1);
  endtask
  // one byte, msb first, then the acknowledge slot
  task automatic xb(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ai, ao);
  endtask
  // register write; nack high if any byte went unanswered
  task automatic wr(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d,
                    output logic nack);
    logic [7:0] q;
    logic       a0;
    logic       a1;
    logic       a2;
    go;
    xb({dev, 1'b0}, 1'b1, q, a0);
    xb(p, 1'b1, q, a1);
    xb(d, 1'b1, q, a2);
    stp;
    nack = a0 | a1 | a2;
  endtask
  // register read: pointer, repeated start, one byte ended by a nack
  task automatic rd(input logic [6:0] dev, input logic [7:0] p, output logic [7:0] q);
    logic [7:0] x;
    logic       a;
    go;
    xb({dev, 1'b0}, 1'b1, x, a);
    xb(p, 1'b1, x, a);
    go;
    xb({dev, 1'b1}, 1'b1, x, a);
    xb(8'hff, 1'b1, q, a);
    stp;
  endtask
endmodule
`default_nettype wire

// *** tb/llc_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench for the table and options bank
module llc_top_test;
  localparam logic [6:0] DEV = llc_pkg::DEV_ADDR_DEFAULT;
  // arbitrary offset: the source flags live outside this bank, so the write is dropped here
  localparam logic [7:0] IRQ_FLAGS_OFS = 8'h40;
  logic        ref_clk_i, rst_b_i, scl, h_oe, d_sda, d_oe;
  logic [15:0] io;
  logic [1:0]  mode_a, mode_b;
  logic [7:0]  pv_a, pv_b;
  logic        io3, io4, io11, io12, drv_a, drv_b, boost, aclr;
  int          num_errors, check_count, n_clr;
  logic [7:0]  ofs [5] = '{8'h28, 8'h29, 8'h2a, 8'h2b, 8'had};
  logic [7:0]  lv [4] = '{8'h2d, 8'hb4, 8'h71, 8'h8e};
  // open-drain wire with pull-up: low while either party pulls
  wire sda = ~(h_oe | (d_oe & ~d_sda));

  llc_top #(.DEV_ADDR(DEV)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda),
    .sda_o(d_sda), .sda_oe_o(d_oe), .io_i(io),
    .logic_mode_low_bank_a_i(mode_a), .logic_mode_low_bank_b_i(mode_b),
    .port_value_bank_a_i(pv_a), .port_value_bank_b_i(pv_b),
    .io3_o(io3), .io4_o(io4), .io11_o(io11), .io12_o(io12),
    .lut_drive_bank_a_o(drv_a), .lut_drive_bank_b_o(drv_b),
    .boost_en_o(boost), .irq_autoclear_o(aclr));
  llc_host_model u_host (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(h_oe));

  // ==========
  // clock, pulse counter and shared checks
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) if (aclr === 1'b1) n_clr++;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] q;
    u_host.rd(DEV, p, q);
    chk("read", e, q);
  endtask
  task automatic wreg(input logic [7:0] p, input logic [7:0] d);
    logic n;
    u_host.wr(DEV, p, d, n);
    chk("ack", 8'h00, {7'h0, n});
  endtask

  // ==========
  // scenarios
  task automatic t_reset;
    chk("outs", 8'h00, {2'h0, boost, aclr, io3, io4, io11, io12});
    foreach (ofs[i]) rchk(ofs[i], 8'h00);
  endtask
  // tables hold data with both banks in mode 0; the host keeps reserved option bits at zero
  task automatic t_regs;
    for (int i = 0; i < 4; i++) wreg(ofs[i], lv[i]);
    for (int i = 0; i < 4; i++) rchk(ofs[i], lv[i]);
    wreg(8'had, 8'h06);
    rchk(8'had, 8'h06);
    chk("boost", 8'h01, {7'h0, boost});
    wreg(8'had, 8'h00);
    chk("boost", 8'h00, {7'h0, boost});
  endtask
  // bank a code is the complement of bank b so the two walk apart
  task automatic t_lut;
    mode_a <= 2'h3;
    mode_b <= 2'h3;
    for (int c = 0; c < 8; c++) begin
      io <= {5'h0, 3'(c), 5'h0, ~3'(c)};
      repeat (4) @(posedge ref_clk_i);
      chk("io11", {7'h0, lv[0][c]}, {7'h0, io11});
      chk("io3", {7'h0, lv[1][7-c]}, {7'h0, io3});
      chk("io12", {7'h0, lv[2][c]}, {7'h0, io12});
      chk("io4", {7'h0, lv[3][7-c]}, {7'h0, io4});
    end
    io <= 16'h0502;
    repeat (4) @(posedge ref_clk_i);
    chk("lut", 8'h3f, {2'h0, drv_a, drv_b, io3, io4, io11, io12});
    mode_a <= 2'h2;
    mode_b <= 2'h1;
    repeat (4) @(posedge ref_clk_i);
    chk("lut", 8'h00, {2'h0, drv_a, drv_b, io3, io4, io11, io12});
  endtask
  // port value reads clear only while the option bit is set
  task automatic t_clear;
    int n0;
    wreg(8'had, 8'h04);
    n0 = n_clr;
    rchk(8'h10, 8'h5a);
    rchk(8'h11, 8'h3c);
    rchk(8'h2b, 8'h8e);
    chk("clears", 8'h02, 8'(n_clr - n0));
    wreg(8'had, 8'h00);
    rchk(8'h10, 8'h5a);
    wreg(IRQ_FLAGS_OFS, 8'hff);
    chk("clears", 8'h02, 8'(n_clr - n0));
  endtask
  // a reset in mid-run brings tables and options back to zero
  task automatic t_rerun;
    wreg(8'had, 8'h02);
    chk("boost", 8'h01, {7'h0, boost});
    rst_b_i <= 1'b0;
    repeat (12) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    @(posedge ref_clk_i);
    chk("boost", 8'h00, {7'h0, boost});
    foreach (ofs[i]) rchk(ofs[i], 8'h00);
  endtask
  // another device address is not answered and stores nothing
  task automatic t_addr;
    logic n;
    u_host.wr(DEV + 7'h1, 8'h28, 8'hff, n);
    chk("nack", 8'h01, {7'h0, n});
    rchk(8'h28, 8'h2d);
  endtask

  // ==========
  // verdict, watchdog and main sequence
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    num_errors++;
    test_done;
  end
  initial begin
    rst_b_i = 1'b0;
    io = 16'h0;
    mode_a = 2'h0;
    mode_b = 2'h0;
    pv_a = 8'h3c;
    pv_b = 8'h5a;
    repeat (12) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    @(posedge ref_clk_i);
    t_reset;
    t_regs;
    t_lut;
    t_clear;
    t_addr;
    t_rerun;
    test_done;
  end
endmodule
`default_nettype wire
